// >>> eat_map.svh
/*
 * register offsets, field positions, reset values and response codes
 * of the event action and trace trigger block.
 * assumes a 32-bit axi4-lite register bus with byte addresses.
 */
`ifndef EAT_MAP_SVH
`define EAT_MAP_SVH

// register byte offsets
`define EAT_OFS_CTRL       8'h00
`define EAT_OFS_GROUP      8'h04
`define EAT_OFS_STATUS     8'h08
`define EAT_OFS_COUNT      8'h0c
`define EAT_OFS_EV_BASE    8'h10
`define EAT_EV_STRIDE      8'h10
`define EAT_EV_ADDR_OFS    8'h00
`define EAT_EV_MASK_OFS    8'h04
`define EAT_EV_CTRL_OFS    8'h08

// control register fields
`define EAT_CTRL_CAPTURE   0
`define EAT_CTRL_CNT_CLR   1
`define EAT_CTRL_RST       32'h0000_0001

// status register fields
`define EAT_ST_COUNT_RUN   0
`define EAT_ST_TRACE_ON    1
`define EAT_ST_OVERFLOW    2
`define EAT_ST_PULSE       3
`define EAT_ST_QUAL_PRES   4
`define EAT_ST_TOG_PRES    5

// event control register fields
`define EAT_EV_EN          0
`define EAT_EV_PULSE       1
`define EAT_EV_CNT_TOG     2
`define EAT_EV_TRC_TOG     3
`define EAT_EV_TRC_QUAL    4
`define EAT_EV_GOTO_EN     5
`define EAT_EV_GOTO_LSB    6
`define EAT_EV_MEMB_LSB    8
`define EAT_EV_ST_VAL_LSB  10
`define EAT_EV_ST_CARE_LSB 14
`define EAT_EV_CTRL_MASK   32'h0003_ffff

// axi responses
`define EAT_RESP_OKAY      2'h0
`define EAT_RESP_SLVERR    2'h2

`endif

// >>> eat_pkg.sv
/*
 * types shared by the event action and trace trigger block.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package eat_pkg;
	// trace recording mode of the active group
	typedef enum logic [1:0] {
		EAT_MODE_ALL,
		EAT_MODE_QUAL,
		EAT_MODE_TOGGLE
	} eat_mode_t;
endpackage : eat_pkg

`default_nettype wire

// >>> eat_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module eat_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;

	// extra pointer bit tells full from empty
	assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
	               (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty = (wr_ptr_reg == rd_ptr_reg);

	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge sys_clk_in) begin
		if (in_valid_in && !full) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
		end else if (in_valid_in && !full) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rd_ptr_reg <= '0;
		end else if (out_ready_in && !empty) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : eat_fifo

`default_nettype wire

// >>> eat_top.sv
/*
 * action logic of the event monitor: per bus cycle event compare,
 * pulse output, counter toggle, trace toggle and trace qualify,
 * axi4-lite register slave and a trace fifo toward trace memory.
 * assumes the bus cycle capture logic runs on sys_clk_in and marks
 * each target bus cycle with one start pulse and one end pulse.
 */
`timescale 1ns/100ps
`default_nettype none
`include "eat_map.svh"

module eat_top #(
	parameter int NUM_EVENTS  = 4,
	parameter int FIFO_DEPTH  = 32,
	parameter int ADDR_W      = 20,
	parameter int DATA_W      = 16,
	parameter int STAT_W      = 4
) (
	// clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_n_in,
	// axi4-lite write channels
	input  wire logic [7:0]             s_axi_awaddr_in,
	input  wire logic                   s_axi_awvalid_in,
	output logic                        s_axi_awready_out,
	input  wire logic [31:0]            s_axi_wdata_in,
	input  wire logic [3:0]             s_axi_wstrb_in,
	input  wire logic                   s_axi_wvalid_in,
	output logic                        s_axi_wready_out,
	output logic [1:0]                  s_axi_bresp_out,
	output logic                        s_axi_bvalid_out,
	input  wire logic                   s_axi_bready_in,
	// axi4-lite read channels
	input  wire logic [7:0]             s_axi_araddr_in,
	input  wire logic                   s_axi_arvalid_in,
	output logic                        s_axi_arready_out,
	output logic [31:0]                 s_axi_rdata_out,
	output logic [1:0]                  s_axi_rresp_out,
	output logic                        s_axi_rvalid_out,
	input  wire logic                   s_axi_rready_in,
	// monitored target bus cycle
	input  wire logic                   cyc_start_in,
	input  wire logic                   cyc_end_in,
	input  wire logic [ADDR_W-1:0]      cyc_addr_in,
	input  wire logic [DATA_W-1:0]      cyc_data_in,
	input  wire logic [STAT_W-1:0]      cyc_status_in,
	// action outputs
	output logic                        scope_pulse_output_out,
	output logic                        count_enable_out,
	output logic [1:0]                  active_group_out,
	// trace memory side
	output logic                        trace_valid_out,
	input  wire logic                   trace_ready_in,
	output logic [ADDR_W+DATA_W+STAT_W-1:0] trace_data_out
);
	localparam int TW = ADDR_W + DATA_W + STAT_W;

	// write path state
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        wr_fire;
	logic [31:0] wr_val;
	// read path state
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        ar_fire;
	logic [31:0] rd_val;
	logic        rd_hit;
	// control state
	logic        capture_en_reg;
	logic [1:0]  group_reg;
	logic        count_run_reg;
	logic [31:0] count_reg;
	logic        trace_on_reg;
	logic        overflow_reg;
	logic        pulse_reg;
	// event storage and compare
	logic [31:0]           ev_ctrl_reg [NUM_EVENTS];
	logic [ADDR_W-1:0]     ev_addr_reg [NUM_EVENTS];
	logic [ADDR_W-1:0]     ev_mask_reg [NUM_EVENTS];
	logic [NUM_EVENTS-1:0] ev_live;
	logic [NUM_EVENTS-1:0] ev_match;
	logic [NUM_EVENTS-1:0] ev_pulse;
	logic [NUM_EVENTS-1:0] ev_cnt;
	logic [NUM_EVENTS-1:0] ev_tog;
	logic [NUM_EVENTS-1:0] ev_qual;
	logic [NUM_EVENTS-1:0] ev_goto;
	logic [NUM_EVENTS-1:0] ev_wr_sel;
	// derived per-cycle terms
	eat_pkg::eat_mode_t    mode;
	logic        qual_present;
	logic        tog_present;
	logic        tog_hit;
	logic        trace_on_now;
	logic        record;
	logic        goto_hit;
	logic [1:0]  goto_group;
	logic        grp_wr;
	logic        fifo_in_ready;

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_strb

	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = (a == `EAT_OFS_CTRL) || (a == `EAT_OFS_GROUP) ||
		      (a == `EAT_OFS_STATUS) || (a == `EAT_OFS_COUNT);
		for (int i = 0; i < NUM_EVENTS; i++) begin
			if ((a >= 8'(`EAT_OFS_EV_BASE + i * `EAT_EV_STRIDE)) &&
			    (a <= 8'(`EAT_OFS_EV_BASE + i * `EAT_EV_STRIDE +
			             `EAT_EV_CTRL_OFS)) && (a[1:0] == 2'h0)) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : is_mapped

	// axi write: address and data taken in either order
	assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready_out  = !w_held_reg && !bvalid_reg;
	assign wr_fire           = aw_held_reg && w_held_reg && !bvalid_reg;
	assign s_axi_bvalid_out  = bvalid_reg;
	assign s_axi_bresp_out   = bresp_reg;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr_in;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata_in;
			w_strb_reg <= s_axi_wstrb_in;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `EAT_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= is_mapped(aw_addr_reg) ? `EAT_RESP_OKAY :
			                                       `EAT_RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid_reg <= 1'b0;
		end
	end

	// byte-merged value for the addressed register, write-only bits zero
	assign wr_val = merge_strb(rd_val_wr(aw_addr_reg), w_data_reg,
	                           w_strb_reg);
	assign grp_wr = wr_fire && (aw_addr_reg == `EAT_OFS_GROUP) &&
	                w_strb_reg[0];

	// axi read: one outstanding read, answer one cycle after ar
	assign s_axi_arready_out = !rvalid_reg;
	assign ar_fire           = s_axi_arvalid_in && !rvalid_reg;
	assign s_axi_rvalid_out  = rvalid_reg;
	assign s_axi_rdata_out   = rdata_reg;
	assign s_axi_rresp_out   = rresp_reg;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= `EAT_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_val;
			rresp_reg  <= rd_hit ? `EAT_RESP_OKAY : `EAT_RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			rvalid_reg <= 1'b0;
		end
	end

	function automatic logic [31:0] rd_val_wr(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == `EAT_OFS_CTRL) begin
			v[`EAT_CTRL_CAPTURE] = capture_en_reg;
		end
		for (int i = 0; i < NUM_EVENTS; i++) begin
			if (a == 8'(`EAT_OFS_EV_BASE + i * `EAT_EV_STRIDE)) begin
				v = 32'(ev_addr_reg[i]);
			end
			if (a == 8'(`EAT_OFS_EV_BASE + i * `EAT_EV_STRIDE +
			            `EAT_EV_MASK_OFS)) begin
				v = 32'(ev_mask_reg[i]);
			end
			if (a == 8'(`EAT_OFS_EV_BASE + i * `EAT_EV_STRIDE +
			            `EAT_EV_CTRL_OFS)) begin
				v = ev_ctrl_reg[i];
			end
		end
		return v;
	endfunction : rd_val_wr

	always_comb begin
		rd_hit = is_mapped(s_axi_araddr_in);
		rd_val = rd_val_wr(s_axi_araddr_in);
		unique case (s_axi_araddr_in)
			`EAT_OFS_GROUP:  rd_val = {30'h0000_0000, group_reg};
			`EAT_OFS_COUNT:  rd_val = count_reg;
			`EAT_OFS_STATUS: begin
				rd_val = 32'h0000_0000;
				rd_val[`EAT_ST_COUNT_RUN] = count_run_reg;
				rd_val[`EAT_ST_TRACE_ON]  = trace_on_reg;
				rd_val[`EAT_ST_OVERFLOW]  = overflow_reg;
				rd_val[`EAT_ST_PULSE]     = pulse_reg;
				rd_val[`EAT_ST_QUAL_PRES] = qual_present;
				rd_val[`EAT_ST_TOG_PRES]  = tog_present;
			end
			default: ;
		endcase
	end

	// control register; default on so tracing runs out of reset
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			capture_en_reg <= 1'(`EAT_CTRL_RST >> `EAT_CTRL_CAPTURE);
		end else if (wr_fire && (aw_addr_reg == `EAT_OFS_CTRL)) begin
			capture_en_reg <= wr_val[`EAT_CTRL_CAPTURE];
		end
	end

	// per-event registers and compare
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_ev
			localparam logic [7:0] BASE =
				8'(`EAT_OFS_EV_BASE + gi * `EAT_EV_STRIDE);
			logic [STAT_W-1:0] st_val;
			logic [STAT_W-1:0] st_care;
			assign st_val  = ev_ctrl_reg[gi][`EAT_EV_ST_VAL_LSB +: STAT_W];
			assign st_care = ev_ctrl_reg[gi][`EAT_EV_ST_CARE_LSB +: STAT_W];
			assign ev_wr_sel[gi] = wr_fire && (aw_addr_reg[7:4] == BASE[7:4]);

			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					ev_addr_reg[gi] <= '0;
					ev_mask_reg[gi] <= '0;
					ev_ctrl_reg[gi] <= 32'h0000_0000;
				end else if (ev_wr_sel[gi]) begin
					if (aw_addr_reg == BASE + `EAT_EV_ADDR_OFS) begin
						ev_addr_reg[gi] <= wr_val[ADDR_W-1:0];
					end
					if (aw_addr_reg == BASE + `EAT_EV_MASK_OFS) begin
						ev_mask_reg[gi] <= wr_val[ADDR_W-1:0];
					end
					if (aw_addr_reg == BASE + `EAT_EV_CTRL_OFS) begin
						ev_ctrl_reg[gi] <= wr_val & `EAT_EV_CTRL_MASK;
					end
				end
			end

			// live: enabled and a member of the active group
			assign ev_live[gi] = ev_ctrl_reg[gi][`EAT_EV_EN] &&
				(ev_ctrl_reg[gi][`EAT_EV_MEMB_LSB +: 2] == group_reg);
			assign ev_match[gi] = capture_en_reg && cyc_start_in &&
				ev_live[gi] &&
				(((cyc_addr_in ^ ev_addr_reg[gi]) & ev_mask_reg[gi]) == '0) &&
				(((cyc_status_in ^ st_val) & st_care) == '0);
			assign ev_pulse[gi] = ev_match[gi] & ev_ctrl_reg[gi][`EAT_EV_PULSE];
			assign ev_cnt[gi]   = ev_match[gi] & ev_ctrl_reg[gi][`EAT_EV_CNT_TOG];
			assign ev_tog[gi]   = ev_live[gi] & ev_ctrl_reg[gi][`EAT_EV_TRC_TOG];
			assign ev_qual[gi]  = ev_live[gi] & ev_ctrl_reg[gi][`EAT_EV_TRC_QUAL];
			assign ev_goto[gi]  = ev_match[gi] & ev_ctrl_reg[gi][`EAT_EV_GOTO_EN];
		end
	endgenerate

	// trace mode follows only the active group's actions
	assign qual_present = |ev_qual;
	assign tog_present  = |ev_tog;
	assign mode = tog_present  ? eat_pkg::EAT_MODE_TOGGLE :
	              qual_present ? eat_pkg::EAT_MODE_QUAL : eat_pkg::EAT_MODE_ALL;
	// several simultaneous toggles each invert, so they act by parity
	assign tog_hit      = ^(ev_tog & ev_match);
	assign trace_on_now = trace_on_reg ^ tog_hit;

	always_comb begin
		record = 1'b0;
		unique case (mode)
			eat_pkg::EAT_MODE_ALL:    record = 1'b1;
			eat_pkg::EAT_MODE_QUAL:   record = |(ev_qual & ev_match);
			eat_pkg::EAT_MODE_TOGGLE: record = trace_on_now |
			                            (|(ev_qual & ev_match));
		endcase
		record = record && cyc_start_in && capture_en_reg;
	end

	// lowest matching event picks the next group
	always_comb begin
		goto_hit   = |ev_goto;
		goto_group = group_reg;
		for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
			if (ev_goto[i]) begin
				goto_group = ev_ctrl_reg[i][`EAT_EV_GOTO_LSB +: 2];
			end
		end
	end

	// software write to the group wins over an event jump
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			group_reg <= 2'h0;
		end else if (grp_wr) begin
			group_reg <= w_data_reg[1:0];
		end else if (goto_hit) begin
			group_reg <= goto_group;
		end
	end
	assign active_group_out = group_reg;

	// trace toggle state; any group change restarts it off
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			trace_on_reg <= 1'b0;
		end else if (grp_wr || goto_hit) begin
			trace_on_reg <= 1'b0;
		end else begin
			trace_on_reg <= trace_on_now;
		end
	end

	// pulse is set at cycle start and dropped at cycle end; a new start
	// in the same clock wins so back-to-back matches never gap
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pulse_reg <= 1'b0;
		end else if (cyc_start_in) begin
			pulse_reg <= |ev_pulse;
		end else if (cyc_end_in) begin
			pulse_reg <= 1'b0;
		end
	end
	assign scope_pulse_output_out = pulse_reg;

	// counter run state and the counter itself
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			count_run_reg <= 1'b0;
		end else begin
			count_run_reg <= count_run_reg ^ (^ev_cnt);
		end
	end
	assign count_enable_out = count_run_reg;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			count_reg <= 32'h0000_0000;
		end else if (wr_fire && (aw_addr_reg == `EAT_OFS_CTRL) &&
		             wr_val[`EAT_CTRL_CNT_CLR]) begin
			count_reg <= 32'h0000_0000;
		end else if (count_run_reg) begin
			count_reg <= count_reg + 32'h0000_0001;
		end
	end

	// the target bus cannot be stalled, so a full fifo drops the cycle
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			overflow_reg <= 1'b0;
		end else if (record && !fifo_in_ready) begin
			overflow_reg <= 1'b1;
		end else if (wr_fire && (aw_addr_reg == `EAT_OFS_STATUS) &&
		             wr_val[`EAT_ST_OVERFLOW] && w_strb_reg[0]) begin
			overflow_reg <= 1'b0;
		end
	end

	eat_fifo #(
		.WIDTH (TW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (record),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    ({cyc_addr_in, cyc_data_in, cyc_status_in}),
		.out_valid_out (trace_valid_out),
		.out_ready_in  (trace_ready_in),
		.out_data_out  (trace_data_out)
	);
endmodule : eat_top

`default_nettype wire

// >>> eat_properties.sv
/*
 * port assertions of eat_top, bound into every instance of it.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module eat_checker #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16,
	parameter int STAT_W = 4
) (
	// clock and reset
	input  wire logic                             sys_clk_in,
	input  wire logic                             rst_n_in,
	// monitored bus cycle
	input  wire logic                             cyc_start_in,
	input  wire logic                             cyc_end_in,
	// register bus
	input  wire logic                             s_axi_awvalid_in,
	input  wire logic                             s_axi_awready_out,
	input  wire logic                             s_axi_wvalid_in,
	input  wire logic                             s_axi_wready_out,
	input  wire logic                             s_axi_bvalid_out,
	// actions
	input  wire logic                             scope_pulse_output_out,
	input  wire logic                             count_enable_out,
	input  wire logic [1:0]                       active_group_out,
	// trace side
	input  wire logic                             trace_valid_out,
	input  wire logic                             trace_ready_in,
	input  wire logic [ADDR_W+DATA_W+STAT_W-1:0]  trace_data_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_pulse_rise;
		$rose(scope_pulse_output_out) |-> $past(cyc_start_in);
	endproperty
	a_pulse_rise: assert property (p_pulse_rise)
		else $error("pulse rose without a cycle start");

	property p_pulse_hold;
		scope_pulse_output_out && !cyc_start_in && !cyc_end_in
			|=> scope_pulse_output_out;
	endproperty
	a_pulse_hold: assert property (p_pulse_hold)
		else $error("pulse dropped inside a cycle");

	property p_pulse_end;
		cyc_end_in && !cyc_start_in |=> !scope_pulse_output_out;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("pulse outlived its cycle");

	property p_count_cause;
		$changed(count_enable_out) |-> $past(cyc_start_in);
	endproperty
	a_count_cause: assert property (p_count_cause)
		else $error("counter state changed outside a cycle start");

	property p_group_cause;
		$changed(active_group_out)
			|-> $past(cyc_start_in) || $rose(s_axi_bvalid_out);
	endproperty
	a_group_cause: assert property (p_group_cause)
		else $error("group changed without cause");

	property p_trace_rise;
		$rose(trace_valid_out) |-> $past(cyc_start_in);
	endproperty
	a_trace_rise: assert property (p_trace_rise)
		else $error("trace record appeared outside a cycle start");

	property p_trace_hold;
		trace_valid_out && !trace_ready_in
			|=> trace_valid_out && $stable(trace_data_out);
	endproperty
	a_trace_hold: assert property (p_trace_hold)
		else $error("trace record lost while stalled");

	property p_write_answer;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
			&& s_axi_wready_out |-> ##2 s_axi_bvalid_out;
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write response late");
endmodule : eat_checker

bind eat_top eat_checker #(
	.ADDR_W(ADDR_W),
	.DATA_W(DATA_W),
	.STAT_W(STAT_W)
) u_eat_checker (
	.sys_clk_in,
	.rst_n_in,
	.cyc_start_in,
	.cyc_end_in,
	.s_axi_awvalid_in,
	.s_axi_awready_out,
	.s_axi_wvalid_in,
	.s_axi_wready_out,
	.s_axi_bvalid_out,
	.scope_pulse_output_out,
	.count_enable_out,
	.active_group_out,
	.trace_valid_out,
	.trace_ready_in,
	.trace_data_out
);

`default_nettype wire

// >>> eat_bus_model.sv
/*
 * target processor model: one bus cycle per accepted request.
 * assumes the bench holds go_in and payload until took_out.
 */
`timescale 1ns/100ps
`default_nettype none

module eat_bus_model (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// request from the bench
	input  wire logic        go_in,
	input  wire logic [19:0] addr_in,
	input  wire logic [15:0] data_in,
	input  wire logic [3:0]  status_in,
	input  wire logic [2:0]  len_in,
	output logic             took_out,
	output logic             busy_out,
	// bus cycle toward the block
	output logic             cyc_start_out,
	output logic             cyc_end_out,
	output logic      [19:0] cyc_addr_out,
	output logic      [15:0] cyc_data_out,
	output logic      [3:0]  cyc_status_out
);
	logic [2:0] cnt_reg;

	// a new cycle may start on the end clock of the last one
	assign took_out = go_in && cnt_reg <= 3'h1;
	assign busy_out = cnt_reg != 3'h0;

	always_ff @(posedge sys_clk_in) begin
		cyc_start_out <= 1'b0;
		cyc_end_out   <= cnt_reg == 3'h1;
		if (!rst_n_in) begin
			cnt_reg     <= 3'h0;
			cyc_end_out <= 1'b0;
		end else if (took_out) begin
			cyc_start_out <= 1'b1;
			cnt_reg       <= len_in;
			{cyc_addr_out, cyc_data_out, cyc_status_out}
				<= {addr_in, data_in, status_in};
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
			// released lines: never leave the old payload standing
			if (cnt_reg == 3'h1)
				{cyc_addr_out, cyc_data_out, cyc_status_out}
					<= ~{cyc_addr_out, cyc_data_out, cyc_status_out};
		end
	end
endmodule : eat_bus_model

`default_nettype wire

// >>> eat_top_tb.sv
/*
 * self-checking bench of eat_top: register bus, bus cycle model and
 * a stalling trace drain. assumes the default widths of eat_top.
 */
`timescale 1ns/100ps
`default_nettype none
`include "eat_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
	fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end end

module eat_top_tb;
	localparam logic [19:0] A = 20'h12340, B = 20'h0abc8, C = 20'h55555;
	logic        clk = 1'b0, rst_n = 1'b0, stall = 1'b0, start_d = 1'b0;
	logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;
	logic [31:0] w_data = 32'h0, r_data, r, seed = 32'h00012fb6;
	logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
	logic        ar_valid = 1'b0, r_ready = 1'b0, tr_ready = 1'b0;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0]  b_resp, r_resp, grp, ev, bb;
	logic        cyc_start, cyc_end, pulse, cnt_en, tr_valid, took, busy;
	logic [19:0] cyc_addr, g_addr = 20'h0;
	logic [15:0] cyc_data, g_data = 16'h0;
	logic [3:0]  cyc_status, g_status = 4'h0;
	logic [2:0]  g_len = 3'h1;
	logic        go = 1'b0;
	logic [39:0] tr_data, tr, exp_tr[$];
	logic [33:0] rr, exp_rd[$];
	logic [1:0]  exp_b[$], exp_ev[$];
	int          fails = 0, checked = 0;

	eat_top u_eat_top (
		.sys_clk_in(clk), .rst_n_in(rst_n),
		.s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
		.s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data),
		.s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_valid),
		.s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp),
		.s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
		.s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
		.s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data),
		.s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
		.s_axi_rready_in(r_ready), .cyc_start_in(cyc_start),
		.cyc_end_in(cyc_end), .cyc_addr_in(cyc_addr),
		.cyc_data_in(cyc_data), .cyc_status_in(cyc_status),
		.scope_pulse_output_out(pulse), .count_enable_out(cnt_en),
		.active_group_out(grp), .trace_valid_out(tr_valid),
		.trace_ready_in(tr_ready), .trace_data_out(tr_data));

	eat_bus_model u_eat_bus_model (
		.sys_clk_in(clk), .rst_n_in(rst_n), .go_in(go),
		.addr_in(g_addr), .data_in(g_data), .status_in(g_status),
		.len_in(g_len), .took_out(took), .busy_out(busy),
		.cyc_start_out(cyc_start), .cyc_end_out(cyc_end),
		.cyc_addr_out(cyc_addr), .cyc_data_out(cyc_data),
		.cyc_status_out(cyc_status));

	always #2 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic done(input string name);
		$display("finished: %s", name);
	endtask : done

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] e = `EAT_RESP_OKAY);
		logic aw, w;
		exp_b.push_back(e);
		aw = 1'b1;
		w = 1'b1;
		aw_addr <= a; w_data <= d; aw_valid <= 1'b1; w_valid <= 1'b1;
		b_ready <= 1'b1;
		do begin
			@(posedge clk);
			if (aw && aw_ready) begin aw = 1'b0; aw_valid <= 1'b0; end
			if (w && w_ready) begin w = 1'b0; w_valid <= 1'b0; end
		end while (aw || w);
		do @(posedge clk); while (!b_valid);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_rd.push_back(e);
		ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
		do @(posedge clk); while (!ar_ready);
		ar_valid <= 1'b0;
		do @(posedge clk); while (!r_valid);
	endtask : rd

	// ev_exp is {pulse, counter running} after the cycle start
	task automatic cyc(input logic [19:0] a, input logic rec,
			input logic [1:0] ev_exp, input logic last);
		logic [31:0] v;
		v = rnd();
		go <= 1'b1; g_addr <= a; g_data <= v[15:0]; g_status <= v[19:16];
		g_len <= {1'b0, v[21:20]} + 3'h1;
		do @(posedge clk); while (!took);
		exp_ev.push_back(ev_exp);
		if (rec) exp_tr.push_back({a, v[15:0], v[19:16]});
		if (last) begin
			go <= 1'b0;
			do @(posedge clk); while (busy);
			@(posedge clk);
		end
	endtask : cyc

	task automatic drain();
		for (int i = 0; i < 500 && exp_tr.size() != 0; i++)
			@(posedge clk);
		// last pop settles only after its edge
		@(posedge clk);
	endtask : drain

	// watchers: oldest note against each result as it appears
	always @(posedge clk) begin
		r = rnd();
		tr_ready <= !stall && r[0];
		if (start_d) begin
			ev = exp_ev.pop_front();
			`CHK({pulse, cnt_en}, ev)
		end
		start_d <= cyc_start;
		if (tr_valid && tr_ready) begin
			tr = exp_tr.pop_front();
			`CHK(tr_data, tr)
		end
		if (r_valid && r_ready) begin
			rr = exp_rd.pop_front();
			`CHK({r_resp, r_data}, rr)
		end
		if (b_valid && b_ready) begin
			bb = exp_b.pop_front();
			`CHK(b_resp, bb)
		end
	end

	initial begin
		#40000;
		fails++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(`EAT_OFS_CTRL, 34'h1);
		rd(`EAT_OFS_GROUP, 34'h0);
		rd(8'hfc, {`EAT_RESP_SLVERR, 32'h0});
		wr(8'hfc, 32'h1, `EAT_RESP_SLVERR);
		done("reset values");
		stall <= 1'b1;
		for (int i = 0; i < 33; i++)
			cyc(20'(rnd() >> 12), i < 32, 2'b00, i == 32);
		rd(`EAT_OFS_STATUS, 34'h4);
		wr(`EAT_OFS_STATUS, 32'h4);
		stall <= 1'b0;
		drain();
		`CHK(tr_valid, 1'b0)
		done("fill and drain");
		wr(8'h10, {12'h0, A}); wr(8'h14, 32'hfffff); wr(8'h18, 32'h7);
		cyc(A, 1'b1, 2'b11, 1'b0);
		cyc(A, 1'b1, 2'b10, 1'b0);
		cyc(B, 1'b1, 2'b00, 1'b1);
		wr(8'h20, {12'h0, B}); wr(8'h24, 32'hfffff); wr(8'h28, 32'h5);
		cyc(B, 1'b1, 2'b01, 1'b0);
		cyc(A, 1'b1, 2'b10, 1'b1);
		done("pulse and counter");
		wr(8'h28, 32'h0); wr(8'h18, 32'h11);
		cyc(C, 1'b0, 2'b00, 1'b0);
		cyc(A, 1'b1, 2'b00, 1'b0);
		cyc(B, 1'b0, 2'b00, 1'b1);
		wr(8'h18, 32'h9);
		cyc(C, 1'b0, 2'b00, 1'b0);
		cyc(A, 1'b1, 2'b00, 1'b0);
		cyc(B, 1'b1, 2'b00, 1'b0);
		cyc(A, 1'b0, 2'b00, 1'b0);
		cyc(C, 1'b0, 2'b00, 1'b1);
		done("qualify and toggle");
		cyc(A, 1'b1, 2'b00, 1'b1);
		wr(`EAT_OFS_GROUP, 32'h1);
		`CHK(grp, 2'h1)
		cyc(C, 1'b1, 2'b00, 1'b1);
		wr(`EAT_OFS_GROUP, 32'h0);
		cyc(B, 1'b0, 2'b00, 1'b1);
		wr(8'h28, 32'h61);
		cyc(B, 1'b0, 2'b00, 1'b1);
		`CHK(grp, 2'h1)
		wr(`EAT_OFS_GROUP, 32'h0);
		done("group change");
		wr(`EAT_OFS_CTRL, 32'h0); wr(8'h18, 32'hb);
		cyc(A, 1'b0, 2'b00, 1'b1);
		wr(`EAT_OFS_CTRL, 32'h1);
		cyc(A, 1'b1, 2'b10, 1'b1);
		drain();
		`CHK(exp_tr.size(), 0)
		done("capture switch");
		wrap_up();
	end
endmodule : eat_top_tb

`default_nettype wire
